// file: verilog/throttle_gpi_pkg.sv
// Operation
// (RL1) Per processor, bit 0 sets on any nonzero throttling seen on its input.
// (RL2) Bit 1 sets for throttle below 12.5%, bit 2 for 12.5% to below 25%.
// (RL3) Bits 3, 4, 5 set for 25-50%, 50-75% and 75-100% throttle bands.
// (RL4) Bit 6 sets when the processor throttled for the full 100% of a window.
// (RL5) Bit 7 sets when throttling exceeds the programmed per-processor throttle limit.
// (RL6) Only bit 7 of each processor register drives the summary host error output.
// (RL7) Input error bit n sets while general input n is low and unmasked.
// (RL8) Flags stay set until written one by host; all three registers reset to zero.
package throttle_gpi_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] CPU1_STATUS_OFFSET = 8'h4c;
	localparam logic [7:0] CPU2_STATUS_OFFSET = 8'h4d;
	localparam logic [7:0] PIN_STATUS_OFFSET  = 8'h4e;
	localparam logic [7:0] CPU1_LIMIT_OFFSET  = 8'h80;
	localparam logic [7:0] CPU2_LIMIT_OFFSET  = 8'h81;
	localparam logic [7:0] PIN_MASK_OFFSET    = 8'h82;
	localparam logic [7:0] INT_STATUS_OFFSET  = 8'h83;
	localparam logic [7:0] INT_MASK_OFFSET    = 8'h84;
	localparam logic [7:0] SUMMARY_OFFSET     = 8'h85;

	// ----------------------------------------------------------------
	// processor status fields
	// ----------------------------------------------------------------
	localparam int THROTTLE_EVENT_FLAG_BIT          = 0;
	localparam int BAND_BELOW_EIGHTH_FLAG_BIT       = 1;
	localparam int BAND_BELOW_QUARTER_FLAG_BIT      = 2;
	localparam int BAND_BELOW_HALF_FLAG_BIT         = 3;
	localparam int BAND_BELOW_THREE_QUARTER_FLAG_BIT = 4;
	localparam int BAND_BELOW_FULL_FLAG_BIT         = 5;
	localparam int FULL_THROTTLE_FLAG_BIT           = 6;
	localparam int LIMIT_ERROR_BIT                  = 7;

	// ----------------------------------------------------------------
	// interrupt status fields
	// ----------------------------------------------------------------
	localparam int INT_CPU1_LIMIT_BIT = 0;
	localparam int INT_CPU2_LIMIT_BIT = 1;
	localparam int INT_PIN_LOW_BIT    = 2;
	localparam int INT_CPU1_FULL_BIT  = 3;
	localparam int INT_CPU2_FULL_BIT  = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] STATUS_RESET   = 8'h00;
	localparam logic [7:0] LIMIT_RESET    = 8'hff;
	localparam logic [7:0] PIN_MASK_RESET = 8'h00;
	localparam logic [7:0] INT_MASK_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int WINDOW_BITS_DEFAULT = 10;

endpackage

// file: verilog/throttle_gpi_error_status.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module throttle_gpi_error_status
	import throttle_gpi_pkg::*;
#(
	parameter int WINDOW_BITS = WINDOW_BITS_DEFAULT
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic       clockEnable,
	// register port
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWrData,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	output logic      [7:0] regRdData,
	// monitored inputs
	input  wire logic       cpu1ThrottleIn_b,
	input  wire logic       cpu2ThrottleIn_b,
	input  wire logic [7:0] generalInputPin,
	// summary outputs
	output logic            hostError,
	output logic            interrupt
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int CW = WINDOW_BITS + 1;
	localparam logic [CW-1:0] WIN_FULL = CW'(1) << WINDOW_BITS;
	localparam logic [CW-1:0] WIN_EIGHTH = WIN_FULL >> 3;
	localparam logic [CW-1:0] WIN_QUARTER = WIN_FULL >> 2;
	localparam logic [CW-1:0] WIN_HALF = WIN_FULL >> 1;
	localparam logic [CW-1:0] WIN_3QUARTER = WIN_HALF + WIN_QUARTER;
	localparam logic [WINDOW_BITS-1:0] WIN_LAST = '1;

	typedef struct packed {
		logic [1:0][7:0]    cpuStatus;
		logic [7:0]         pinStatus;
		logic [1:0][7:0]    limit;
		logic [7:0]         pinMask;
		logic [7:0]         intStatus;
		logic [7:0]         intMask;
		logic [WINDOW_BITS-1:0] winCnt;
		logic [1:0][CW-1:0] lowCnt;
		logic [7:0]         rdData;
	} state_s;

	state_s         state_reg;
	state_s         state_next;
	logic [1:0]     throttling;
	logic           windowEnd;
	logic [1:0][CW-1:0] total;
	logic [1:0][7:0]    cpuSet;
	logic [7:0]     pinSet;
	logic [7:0]     intSet;

	assign throttling = {~cpu2ThrottleIn_b, ~cpu1ThrottleIn_b};
	assign windowEnd  = (state_reg.winCnt == WIN_LAST);

	// ----------------------------------------------------------------
	// per-processor band classification
	// ----------------------------------------------------------------
	generate
		for (genvar i = 0; i < 2; i++) begin : g_cpu
			logic [CW+7:0] scaledCnt;
			logic [CW+7:0] scaledLimit;
			logic          active;

			assign total[i] = state_reg.lowCnt[i] + CW'(throttling[i]);
			assign active = windowEnd && (total[i] != '0);
			assign scaledCnt = {total[i], 8'h00};
			assign scaledLimit = (CW+8)'(state_reg.limit[i]) << WINDOW_BITS;

			// (RL1) any throttling
			assign cpuSet[i][THROTTLE_EVENT_FLAG_BIT] = throttling[i];
			// (RL2) low bands
			assign cpuSet[i][BAND_BELOW_EIGHTH_FLAG_BIT] = active && (total[i] < WIN_EIGHTH);
			assign cpuSet[i][BAND_BELOW_QUARTER_FLAG_BIT] = active && (total[i] >= WIN_EIGHTH)
				&& (total[i] < WIN_QUARTER);
			// (RL3) upper bands
			assign cpuSet[i][BAND_BELOW_HALF_FLAG_BIT] = active && (total[i] >= WIN_QUARTER)
				&& (total[i] < WIN_HALF);
			assign cpuSet[i][BAND_BELOW_THREE_QUARTER_FLAG_BIT] = active && (total[i] >= WIN_HALF)
				&& (total[i] < WIN_3QUARTER);
			assign cpuSet[i][BAND_BELOW_FULL_FLAG_BIT] = active && (total[i] >= WIN_3QUARTER)
				&& (total[i] < WIN_FULL);
			// (RL4) full window
			assign cpuSet[i][FULL_THROTTLE_FLAG_BIT] = windowEnd && (total[i] == WIN_FULL);
			// (RL5) limit compare
			assign cpuSet[i][LIMIT_ERROR_BIT] = windowEnd && (scaledCnt > scaledLimit);
		end
	endgenerate

	// (RL7) low unmasked pins
	assign pinSet = ~generalInputPin & ~state_reg.pinMask;

	always_comb begin
		intSet = 8'h00;
		intSet[INT_CPU1_LIMIT_BIT] = cpuSet[0][LIMIT_ERROR_BIT];
		intSet[INT_CPU2_LIMIT_BIT] = cpuSet[1][LIMIT_ERROR_BIT];
		intSet[INT_PIN_LOW_BIT] = |pinSet;
		intSet[INT_CPU1_FULL_BIT] = cpuSet[0][FULL_THROTTLE_FLAG_BIT];
		intSet[INT_CPU2_FULL_BIT] = cpuSet[1][FULL_THROTTLE_FLAG_BIT];
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [1:0][7:0] cpuClr;
		logic [7:0]      pinClr;
		logic [7:0]      intClr;
		cpuClr = '0;
		pinClr = 8'h00;
		intClr = 8'h00;
		state_next = state_reg;

		// measurement window
		state_next.winCnt = state_reg.winCnt + WINDOW_BITS'(1);
		for (int k = 0; k < 2; k++) begin
			state_next.lowCnt[k] = windowEnd ? '0 : total[k];
		end

		// register writes
		if (regWrite) begin
			if (regAddr == CPU1_STATUS_OFFSET) begin
				cpuClr[0] = regWrData;
			end else if (regAddr == CPU2_STATUS_OFFSET) begin
				cpuClr[1] = regWrData;
			end else if (regAddr == PIN_STATUS_OFFSET) begin
				pinClr = regWrData;
			end else if (regAddr == CPU1_LIMIT_OFFSET) begin
				state_next.limit[0] = regWrData;
			end else if (regAddr == CPU2_LIMIT_OFFSET) begin
				state_next.limit[1] = regWrData;
			end else if (regAddr == PIN_MASK_OFFSET) begin
				state_next.pinMask = regWrData;
			end else if (regAddr == INT_MASK_OFFSET) begin
				state_next.intMask = regWrData;
			end
		end

		// register reads
		if (regRead) begin
			if (regAddr == CPU1_STATUS_OFFSET) begin
				state_next.rdData = state_reg.cpuStatus[0];
			end else if (regAddr == CPU2_STATUS_OFFSET) begin
				state_next.rdData = state_reg.cpuStatus[1];
			end else if (regAddr == PIN_STATUS_OFFSET) begin
				state_next.rdData = state_reg.pinStatus;
			end else if (regAddr == CPU1_LIMIT_OFFSET) begin
				state_next.rdData = state_reg.limit[0];
			end else if (regAddr == CPU2_LIMIT_OFFSET) begin
				state_next.rdData = state_reg.limit[1];
			end else if (regAddr == PIN_MASK_OFFSET) begin
				state_next.rdData = state_reg.pinMask;
			end else if (regAddr == INT_STATUS_OFFSET) begin
				state_next.rdData = state_reg.intStatus;
				intClr = 8'hff;
			end else if (regAddr == INT_MASK_OFFSET) begin
				state_next.rdData = state_reg.intMask;
			end else if (regAddr == SUMMARY_OFFSET) begin
				state_next.rdData = {7'h00, hostError};
			end else begin
				state_next.rdData = UNMAPPED_READ;
			end
		end else begin
			state_next.rdData = 8'h00;
		end

		// (RL8) sticky flags, write one clears, interrupt status clears on read, set wins
		for (int k = 0; k < 2; k++) begin
			state_next.cpuStatus[k] = (state_reg.cpuStatus[k] & ~cpuClr[k]) | cpuSet[k];
		end
		state_next.pinStatus = (state_reg.pinStatus & ~pinClr) | pinSet;
		state_next.intStatus = (state_reg.intStatus & ~intClr) | intSet;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// (RL8) zero reset, limits reset to 8'hff
			state_reg.cpuStatus <= {STATUS_RESET, STATUS_RESET};
			state_reg.pinStatus <= STATUS_RESET;
			state_reg.limit     <= {LIMIT_RESET, LIMIT_RESET};
			state_reg.pinMask   <= PIN_MASK_RESET;
			state_reg.intStatus <= STATUS_RESET;
			state_reg.intMask   <= INT_MASK_RESET;
			state_reg.winCnt    <= '0;
			state_reg.lowCnt    <= '0;
			state_reg.rdData    <= 8'h00;
		end else if (clockEnable) begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign regRdData = state_reg.rdData;
	// (RL6) limit bits only
	assign hostError = state_reg.cpuStatus[0][LIMIT_ERROR_BIT] | state_reg.cpuStatus[1][LIMIT_ERROR_BIT];
	assign interrupt = |(state_reg.intStatus & state_reg.intMask);

endmodule

// file: tb/throttle_gpi_monitor.sv
`timescale 1ns/100ps
module throttle_gpi_monitor
	import throttle_gpi_pkg::*;
(
	// watched ports
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic       clockEnable,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regRdData,
	input wire logic [7:0] generalInputPin,
	input wire logic       hostError,
	input wire logic       interrupt
);
	logic [7:0] maskReg;
	logic [7:0] intMaskReg;
	logic [7:0] pinLowReg;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// shadows of the masks, unmasked low pins
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			maskReg <= PIN_MASK_RESET;
			intMaskReg <= INT_MASK_RESET;
			pinLowReg <= 8'h00;
		end else if (clockEnable) begin
			if (regWrite && regAddr == PIN_MASK_OFFSET) maskReg <= regWrData;
			if (regWrite && regAddr == INT_MASK_OFFSET) intMaskReg <= regWrData;
			pinLowReg <= ~generalInputPin & ~maskReg;
		end
	end
	a_read_idle: assert property ($past(clockEnable) && !$past(regRead) |-> regRdData == 8'h00)
		else $error("read data not idle");
	a_host_clear: assert property ($fell(hostError) |-> $past(regWrite) && $past(regWrData[7]))
		else $error("host error dropped without clear");
	a_host_match: assert property ($past(clockEnable) && $past(regRead) && $past(regAddr) == CPU1_STATUS_OFFSET
		&& regRdData[7] |-> $past(hostError)) else $error("limit flag not on host error");
	a_pin_cleared: assert property (clockEnable && regWrite && regAddr == PIN_STATUS_OFFSET && regWrData == 8'hff
		&& (&generalInputPin) ##1 (&generalInputPin) ##1 (clockEnable && regRead && regAddr == PIN_STATUS_OFFSET
		&& (&generalInputPin)) |=> regRdData == 8'h00) else $error("pin flags not cleared");
	a_pin_set: assert property (clockEnable && regRead && regAddr == PIN_STATUS_OFFSET
		|=> (regRdData & $past(pinLowReg)) == $past(pinLowReg)) else $error("low pin not flagged");
	a_int_masked: assert property (interrupt |-> intMaskReg != 8'h00)
		else $error("interrupt while all masked");
	a_unmapped_zero: assert property (clockEnable && regRead && (regAddr < 8'h4c || regAddr > 8'h85)
		|=> regRdData == 8'h00) else $error("unmapped read not zero");
	a_summary_read: assert property (clockEnable && regRead && regAddr == SUMMARY_OFFSET
		|=> regRdData[0] == $past(hostError)) else $error("summary bit wrong");
endmodule
bind throttle_gpi_error_status throttle_gpi_monitor mon (.clock(clock), .rst_b(rst_b),
	.clockEnable(clockEnable), .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
	.regRead(regRead), .regRdData(regRdData), .generalInputPin(generalInputPin),
	.hostError(hostError), .interrupt(interrupt));

// file: tb/throttle_gpi_partner.sv
`timescale 1ns/100ps
module throttle_gpi_partner (
	// pattern control
	input  wire logic       clock,
	input  wire logic       rst_b,
	input  wire logic [3:0] cpu1Count,
	input  wire logic [3:0] cpu2Count,
	input  wire logic [7:0] pinLow,
	// driven pins
	output logic            cpu1ThrottleIn_b,
	output logic            cpu2ThrottleIn_b,
	output logic      [7:0] generalInputPin
);
	logic [2:0] phaseReg;
	// low for count cycles of every eight
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) phaseReg <= 3'h0;
		else phaseReg <= phaseReg + 3'h1;
	end
	assign cpu1ThrottleIn_b = !({1'b0, phaseReg} < cpu1Count);
	assign cpu2ThrottleIn_b = !({1'b0, phaseReg} < cpu2Count);
	assign generalInputPin = ~pinLow;
endmodule

// file: tb/throttle_gpi_error_status_tb_top.sv
`timescale 1ns/100ps
module throttle_gpi_error_status_tb_top;
	import throttle_gpi_pkg::*;
	localparam int WB = 3;
	localparam int W = 1 << WB;
	logic       clock, rst_b, clockEnable, regWrite, regRead, thr1_b, thr2_b, hostError, interrupt;
	logic [7:0] regAddr, regWrData, regRdData, pins, pinLow;
	logic [3:0] cpu1Count, cpu2Count;
	int         errorCnt, checks, c;
	throttle_gpi_error_status #(.WINDOW_BITS(WB)) dut (.clock(clock), .rst_b(rst_b), .clockEnable(clockEnable),
		.regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
		.regRdData(regRdData), .cpu1ThrottleIn_b(thr1_b), .cpu2ThrottleIn_b(thr2_b),
		.generalInputPin(pins), .hostError(hostError), .interrupt(interrupt));
	throttle_gpi_partner far (.clock(clock), .rst_b(rst_b), .cpu1Count(cpu1Count), .cpu2Count(cpu2Count),
		.pinLow(pinLow), .cpu1ThrottleIn_b(thr1_b), .cpu2ThrottleIn_b(thr2_b), .generalInputPin(pins));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	function automatic logic [7:0] expBand(int n, int lim);
		expBand = (n == 0) ? 8'h00 : (n * 8 < W) ? 8'h03 : (n * 4 < W) ? 8'h05 : (n * 2 < W) ? 8'h09 :
			(n * 4 < 3 * W) ? 8'h11 : (n < W) ? 8'h21 : 8'h41;
		if (n * 256 > lim * W) expBand[7] = 1'b1;
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			errorCnt++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 check(regRdData, exp);
	endtask
	task automatic resetValues();
		rd(CPU1_STATUS_OFFSET, 8'h00);
		rd(CPU2_STATUS_OFFSET, 8'h00);
		rd(PIN_STATUS_OFFSET, 8'h00);
		rd(8'h90, UNMAPPED_READ);
	endtask
	task automatic bandSweep();
		int steps[5] = '{1, 2, 4, 6, 8};
		wr(CPU1_LIMIT_OFFSET, 8'h80);
		foreach (steps[i]) begin
			c = steps[i];
			cpu1Count <= 4'(c);
			cpu2Count <= 4'(W - c);
			repeat (2 * W) @(posedge clock);
			wr(CPU1_STATUS_OFFSET, 8'hff);
			wr(CPU2_STATUS_OFFSET, 8'hff);
			repeat (W + 2) @(posedge clock);
			rd(CPU1_STATUS_OFFSET, expBand(c, 8'h80));
			rd(CPU2_STATUS_OFFSET, expBand(W - c, 8'hff));
			check({7'h00, hostError}, {7'h00, c * 2 > W});
			rd(SUMMARY_OFFSET, {7'h00, c * 2 > W});
		end
	endtask
	task automatic pinScenario();
		wr(PIN_MASK_OFFSET, 8'h0f);
		wr(INT_MASK_OFFSET, 8'h04);
		pinLow <= 8'hff;
		repeat (3) @(posedge clock);
		pinLow <= 8'h00;
		repeat (2) @(posedge clock);
		#1 check({7'h00, interrupt}, 8'h01);
		rd(PIN_STATUS_OFFSET, 8'hf0);
		rd(INT_STATUS_OFFSET, 8'h0d);
		check({7'h00, interrupt}, 8'h00);
		wr(PIN_STATUS_OFFSET, 8'h10);
		rd(PIN_STATUS_OFFSET, 8'he0);
		wr(PIN_STATUS_OFFSET, 8'hff);
		rd(PIN_STATUS_OFFSET, 8'h00);
	endtask
	// clear lost while the clock enable is low
	task automatic freezeScenario();
		@(posedge clock);
		pinLow <= 8'h10;
		repeat (2) @(posedge clock);
		pinLow <= 8'h00;
		clockEnable <= 1'b0;
		wr(PIN_STATUS_OFFSET, 8'hff);
		clockEnable <= 1'b1;
		rd(PIN_STATUS_OFFSET, 8'h10);
		check({7'h00, interrupt}, 8'h01);
	endtask
	task automatic testDone();
		$display("errors %0d checks %0d", errorCnt, checks);
		if (errorCnt == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{rst_b, regWrite, regRead, regAddr, regWrData, pinLow, cpu1Count, cpu2Count} = '0;
		clockEnable = 1'b1;
		errorCnt = 0;
		checks = 0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		resetValues();
		bandSweep();
		pinScenario();
		freezeScenario();
		testDone();
	end
endmodule
